// >>> common/uam_defines.svh
`ifndef UAM_DEFINES_SVH
`define UAM_DEFINES_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define UAM_OFS_CTRL 6'h00
`define UAM_OFS_LIVE 6'h04
`define UAM_OFS_EVT 6'h08
`define UAM_OFS_MASK 6'h0C
`define UAM_OFS_DIDX 6'h10
`define UAM_OFS_DDAT 6'h14
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define UAM_CTRL_PROT 0
`define UAM_CTRL_FORCE_LSB 1
`define UAM_CTRL_RST 5'h00
`define UAM_MASK_RST 29'h0000000
`define UAM_EVT_SWITCH 24
`define UAM_EVT_OVER_LSB 25
`define UAM_LIVE_SEL 24
// ----------------------------------------
// Uplink frame and counts
// ----------------------------------------
`define UAM_SYNC_BYTE 8'hF6
`define UAM_IDLE_BYTE 8'h00
`define UAM_LAST_SLOT 4'hB
`define UAM_SYNC_HITS 2'h2
`define UAM_SYNC_MISS 2'h2
`define UAM_MAX_FRAME 14'h3E80
`define UAM_BER_WIN 125000
`define UAM_BER_LIMIT 8'h01
`define UAM_DDM_ITEMS 3'h5
`define UAM_DDM_LAST 6'h3B
`endif

// >>> common/uam_pkg.sv
package uam_pkg;
  typedef logic [7:0] uam_byte_t;
  typedef enum logic [1:0] {
    UAM_DDM_IDLE = 2'b00,
    UAM_DDM_REQ = 2'b01,
    UAM_DDM_NEXT = 2'b10
  } uam_ddm_state_t;
endpackage

// >>> hw/uam_top.sv
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "uam_defines.svh"
// Behaviour
// - Six STM-1, four gigabit ports and one VC4 slot-multiplexed onto uplinks and back.
// - With protection on, traffic uses uplink one, moving to uplink two on failure.
// - With protection off, uplink two is held down with laser off.
// - Gigabit ports run auto-negotiation, or forced 1000 Mbit/s full duplex.
// - Gigabit frames up to 16000 bytes are forwarded; longer ones flagged.
// - STM-1 path overhead D1-D12 bytes pass unchanged.
// - STM-1 B1 and B2 parity checked per port.
// - One backplane VC4 channel is carried alongside front ports.
// - Uplink signal-loss indication follows loss of optical input.
// - Uplink sync indication high while received uplink frame is aligned.
// - Gigabit port signal-loss indication follows loss of optical input.
// - Gigabit link indication high while Ethernet link is up and optical input is present.
// - STM-1 signal-loss indication follows loss of optical input.
// - STM-1 error flag set above threshold, cleared on error-free window.
// - Diagnostics of fitted optical modules are polled continuously.
// - Error threshold corresponds to bit error ratio of 1e-6.
module uam_top import uam_pkg::*; #(
  parameter int BER_WIN = `UAM_BER_WIN
) (
  input wire logic clk_in, // 200 MHz clock
  input wire logic rst_n_in, // Async reset, active low
  input wire logic ce_in, // Clock enable
  input wire logic [10:0][7:0] ch_dat_in, // Tributary bytes: 0-5 STM, 6-9 GE, 10 VC4
  input wire logic [10:0] ch_vld_in, // Tributary byte offered
  input wire logic [3:0] ge_eof_in, // Last byte of a GE frame
  input wire logic [5:0] stm_fs_in, // STM frame start
  input wire logic [5:0] stm_rs_in, // Byte lies in regenerator overhead
  input wire logic [5:0][7:0] stm_b1_in, // Received B1, valid at frame start
  input wire logic [5:0][7:0] stm_b2_in, // Received B2, valid at frame start
  input wire logic [1:0][7:0] up_rx_dat_in, // Uplink receive bytes
  input wire logic [1:0] up_rx_vld_in, // Uplink receive byte valid
  input wire logic [1:0] up_los_in, // Uplink optical loss pin
  input wire logic [3:0] ge_los_in, // GE optical loss pin
  input wire logic [3:0] ge_link_in, // GE PCS link pin
  input wire logic [5:0] stm_los_in, // STM optical loss pin
  input wire logic [11:0] ddm_fit_in, // Diagnostic module fitted pin
  input wire logic ddm_ack_in, // Diagnostic read done
  input wire logic [15:0] ddm_dat_in, // Diagnostic value
  output logic [10:0] ch_take_out, // Tributary byte taken
  output logic [7:0] up_tx_dat_out, // Uplink transmit byte
  output logic [1:0] up_tx_en_out, // Uplink laser enable
  output logic [10:0][7:0] rx_ch_dat_out, // Demultiplexed bytes
  output logic [10:0] rx_ch_vld_out, // Demultiplexed byte valid
  output logic [3:0] ge_an_en_out, // GE auto-negotiation enable
  output logic [1:0] up_los_out, // Uplink signal loss
  output logic [1:0] up_sync_out, // Uplink frame sync
  output logic [3:0] ge_los_out, // GE signal loss
  output logic [3:0] ge_link_out, // GE link up
  output logic [5:0] stm_los_out, // STM signal loss
  output logic [5:0] stm_err_out, // STM error ratio flag
  output logic ddm_req_out, // Diagnostic read request
  output logic [5:0] ddm_addr_out, // Diagnostic entry index
  output logic irq_out, // Interrupt, level
  input wire logic [5:0] s_axi_awaddr, // AXI write address
  input wire logic s_axi_awvalid, // AXI
  output logic s_axi_awready, // AXI
  input wire logic [31:0] s_axi_wdata, // AXI
  input wire logic [3:0] s_axi_wstrb, // AXI
  input wire logic s_axi_wvalid, // AXI
  output logic s_axi_wready, // AXI
  output logic [1:0] s_axi_bresp, // AXI
  output logic s_axi_bvalid, // AXI
  input wire logic s_axi_bready, // AXI
  input wire logic [5:0] s_axi_araddr, // AXI read address
  input wire logic s_axi_arvalid, // AXI
  output logic s_axi_arready, // AXI
  output logic [31:0] s_axi_rdata, // AXI
  output logic [1:0] s_axi_rresp, // AXI
  output logic s_axi_rvalid, // AXI
  input wire logic s_axi_rready // AXI
);
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) o[i*8 +: 8] = n[i*8 +: 8];
    end
    return o;
  endfunction
  function automatic logic [3:0] ones(input logic [7:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 8; i++) c = c + {3'h0, v[i]};
    return c;
  endfunction
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [29:0] pin_a_q, pin_b_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_a_q <= '0;
      pin_b_q <= '0;
    end else if (ce_in) begin
      pin_a_q <= {ddm_fit_in, stm_los_in, ge_link_in, ge_los_in, up_los_in};
      pin_b_q <= pin_a_q;
    end
  end
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [4:0] ctrl_q;
  logic [28:0] evt_q, mask_q;
  logic [5:0] didx_q, aw_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic aw_got_q, w_got_q, sel_q;
  logic [15:0] ddm_mem_q [60];
  logic [24:0] live_q;
  logic [28:0] evt_set;
  logic do_wr;
  assign do_wr = aw_got_q && w_got_q && !s_axi_bvalid;
  assign live_q = {sel_q, stm_err_out, stm_los_out, ge_link_out, ge_los_out, up_sync_out,
                   up_los_out};
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_q <= '0;
      wd_q <= '0;
      ws_q <= '0;
      ctrl_q <= `UAM_CTRL_RST;
      mask_q <= `UAM_MASK_RST;
      didx_q <= '0;
    end else if (ce_in) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= s_axi_awaddr;
        aw_got_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
        w_got_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        case (aw_q)
          `UAM_OFS_CTRL: ctrl_q <= 5'(merge({27'h0, ctrl_q}, wd_q, ws_q));
          `UAM_OFS_MASK: mask_q <= 29'(merge({3'h0, mask_q}, wd_q, ws_q));
          `UAM_OFS_DIDX: didx_q <= 6'(merge({26'h0, didx_q}, wd_q, ws_q));
          `UAM_OFS_EVT, `UAM_OFS_LIVE, `UAM_OFS_DDAT: s_axi_bresp <= 2'h0;
          default: s_axi_bresp <= 2'h2;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'h0;
    end else if (ce_in) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          `UAM_OFS_CTRL: s_axi_rdata <= {27'h0, ctrl_q};
          `UAM_OFS_LIVE: s_axi_rdata <= {7'h0, live_q};
          `UAM_OFS_EVT: s_axi_rdata <= {3'h0, evt_q};
          `UAM_OFS_MASK: s_axi_rdata <= {3'h0, mask_q};
          `UAM_OFS_DIDX: s_axi_rdata <= {26'h0, didx_q};
          `UAM_OFS_DDAT: s_axi_rdata <= {16'h0, ddm_mem_q[didx_q]};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // Events and interrupt
  // ----------------------------------------
  logic [24:0] live_old_q;
  logic [3:0] over_q;
  logic sw_q;
  // A fresh event beats a clear in the same cycle
  assign evt_set = {over_q, sw_q, live_q[23:0] ^ live_old_q[23:0]};
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      live_old_q <= '0;
      evt_q <= '0;
      irq_out <= 1'b0;
    end else if (ce_in) begin
      live_old_q <= live_q;
      evt_q <= (do_wr && aw_q == `UAM_OFS_EVT) ?
               ((evt_q & ~29'(merge(32'h0, wd_q, ws_q))) | evt_set) : (evt_q | evt_set);
      irq_out <= |(evt_q & mask_q);
    end
  end
  a_irq_gated: assert property (@(posedge clk_in) disable iff (!rst_n_in || !ce_in)
    irq_out == $past(|(evt_q & mask_q))) else $error("irq not masked status");
  a_evt_change: assert property (@(posedge clk_in) disable iff (!rst_n_in || !ce_in)
    $past(ce_in) && (live_q[1:0] != $past(live_q[1:0])) |=> |evt_q[1:0])
    else $error("change lost");
  // ----------------------------------------
  // Indications and protection
  // ----------------------------------------
  logic [1:0] fsync_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      up_los_out <= '0;
      up_sync_out <= '0;
      ge_los_out <= '0;
      ge_link_out <= '0;
      stm_los_out <= '0;
      ge_an_en_out <= '0;
      up_tx_en_out <= '0;
      sel_q <= 1'b0;
      sw_q <= 1'b0;
    end else if (ce_in) begin
      up_los_out <= pin_b_q[1:0];
      up_sync_out <= fsync_q;
      ge_los_out <= pin_b_q[5:2];
      ge_link_out <= pin_b_q[9:6] & ~pin_b_q[5:2];
      stm_los_out <= pin_b_q[15:10];
      ge_an_en_out <= ~ctrl_q[4:1];
      up_tx_en_out <= {ctrl_q[`UAM_CTRL_PROT], 1'b1};
      sw_q <= 1'b0;
      if (!ctrl_q[`UAM_CTRL_PROT]) sel_q <= 1'b0;
      else if (!sel_q && (up_los_out[0] || !up_sync_out[0])) begin
        sel_q <= 1'b1;
        sw_q <= 1'b1;
      end
    end
  end
  a_switch_fail: assert property (@(posedge clk_in) disable iff (!rst_n_in || !ce_in)
    ctrl_q[0] && !sel_q && (up_los_out[0] || !up_sync_out[0]) |=> sel_q)
    else $error("no switch on failure");
  a_up2_dark: assert property (@(posedge clk_in) disable iff (!rst_n_in || !ce_in)
    !ctrl_q[0] |=> !up_tx_en_out[1] && !sel_q) else $error("uplink two lit");
  // ----------------------------------------
  // Transmit multiplexer
  // ----------------------------------------
  logic [3:0] tslot_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tslot_q <= '0;
      up_tx_dat_out <= `UAM_IDLE_BYTE;
      ch_take_out <= '0;
    end else if (ce_in) begin
      tslot_q <= (tslot_q == `UAM_LAST_SLOT) ? 4'h0 : tslot_q + 4'h1;
      ch_take_out <= '0;
      if (tslot_q == 4'h0) up_tx_dat_out <= `UAM_SYNC_BYTE;
      else if (ch_vld_in[tslot_q - 4'h1]) begin
        // Bytes pass untouched, overhead included
        up_tx_dat_out <= ch_dat_in[tslot_q - 4'h1];
        ch_take_out[tslot_q - 4'h1] <= 1'b1;
      end else up_tx_dat_out <= `UAM_IDLE_BYTE;
    end
  end
  // ----------------------------------------
  // Receive framers and demultiplexer
  // ----------------------------------------
  logic [1:0][3:0] rpos_q;
  logic [1:0][1:0] hit_q, miss_q;
  logic [1:0] rv;
  assign rv = up_rx_vld_in & {ctrl_q[`UAM_CTRL_PROT], 1'b1};
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rpos_q <= '0;
      hit_q <= '0;
      miss_q <= '0;
      fsync_q <= '0;
    end else if (ce_in) begin
      for (int u = 0; u < 2; u++) begin
        if (u == 1 && !ctrl_q[`UAM_CTRL_PROT]) begin
          fsync_q[1] <= 1'b0;
          hit_q[1] <= '0;
        end else if (rv[u]) begin
          rpos_q[u] <= (rpos_q[u] == `UAM_LAST_SLOT) ? 4'h0 : rpos_q[u] + 4'h1;
          if (hit_q[u] == 2'h0 && !fsync_q[u]) begin
            if (up_rx_dat_in[u] == `UAM_SYNC_BYTE) begin
              rpos_q[u] <= 4'h1;
              hit_q[u] <= 2'h1;
            end
          end else if (rpos_q[u] == 4'h0) begin
            if (up_rx_dat_in[u] == `UAM_SYNC_BYTE) begin
              miss_q[u] <= '0;
              if (hit_q[u] == `UAM_SYNC_HITS) fsync_q[u] <= 1'b1;
              else hit_q[u] <= hit_q[u] + 2'h1;
            end else if (miss_q[u] + 2'h1 == `UAM_SYNC_MISS || !fsync_q[u]) begin
              fsync_q[u] <= 1'b0;
              hit_q[u] <= '0;
              miss_q[u] <= '0;
            end else miss_q[u] <= miss_q[u] + 2'h1;
          end
        end
      end
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_ch_dat_out <= '0;
      rx_ch_vld_out <= '0;
    end else if (ce_in) begin
      rx_ch_vld_out <= '0;
      if (rv[sel_q] && fsync_q[sel_q] && rpos_q[sel_q] != 4'h0) begin
        rx_ch_dat_out[rpos_q[sel_q] - 4'h1] <= up_rx_dat_in[sel_q];
        rx_ch_vld_out[rpos_q[sel_q] - 4'h1] <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // GE frame length
  // ----------------------------------------
  logic [3:0][13:0] glen_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      glen_q <= '0;
      over_q <= '0;
    end else if (ce_in) begin
      over_q <= '0;
      for (int g = 0; g < 4; g++) begin
        if (ch_take_out[6 + g]) begin
          if (ge_eof_in[g]) glen_q[g] <= '0;
          else if (glen_q[g] == `UAM_MAX_FRAME - 14'h1) over_q[g] <= 1'b1;
          else glen_q[g] <= glen_q[g] + 14'h1;
        end
      end
    end
  end
  // ----------------------------------------
  // STM parity and error ratio
  // ----------------------------------------
  logic [5:0][7:0] b1_q, b2_q;
  logic [5:0][16:0] win_q;
  logic [5:0][7:0] ecnt_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      b1_q <= '0;
      b2_q <= '0;
      win_q <= '0;
      ecnt_q <= '0;
      stm_err_out <= '0;
    end else if (ce_in) begin
      for (int p = 0; p < 6; p++) begin
        if (stm_fs_in[p]) begin
          b1_q[p] <= '0;
          b2_q[p] <= '0;
          if (ecnt_q[p] < 8'hF0)
            ecnt_q[p] <= ecnt_q[p] + {4'h0, ones(b1_q[p] ^ stm_b1_in[p])}
                         + {4'h0, ones(b2_q[p] ^ stm_b2_in[p])};
        end else if (ch_take_out[p]) begin
          b1_q[p] <= b1_q[p] ^ ch_dat_in[p];
          if (!stm_rs_in[p]) b2_q[p] <= b2_q[p] ^ ch_dat_in[p];
        end
        if (ch_take_out[p]) begin
          if (win_q[p] == 17'(BER_WIN - 1)) begin
            win_q[p] <= '0;
            ecnt_q[p] <= '0;
            if (ecnt_q[p] > `UAM_BER_LIMIT) stm_err_out[p] <= 1'b1;
            else if (ecnt_q[p] == 8'h00) stm_err_out[p] <= 1'b0;
          end else win_q[p] <= win_q[p] + 17'h1;
        end
      end
    end
  end
  // ----------------------------------------
  // Module diagnostics poller
  // ----------------------------------------
  uam_ddm_state_t dst_q;
  logic [2:0] ditem_q;
  logic [3:0] dmod_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dst_q <= UAM_DDM_IDLE;
      ddm_req_out <= 1'b0;
      ddm_addr_out <= '0;
      ditem_q <= '0;
      dmod_q <= '0;
    end else if (ce_in) begin
      case (dst_q)
        UAM_DDM_IDLE: begin
          if (pin_b_q[16 + dmod_q]) begin
            ddm_req_out <= 1'b1;
            ddm_addr_out <= 6'(dmod_q * 5) + {3'h0, ditem_q};
            dst_q <= UAM_DDM_REQ;
          end else dst_q <= UAM_DDM_NEXT;
        end
        UAM_DDM_REQ: begin
          if (ddm_ack_in) begin
            ddm_req_out <= 1'b0;
            ddm_mem_q[ddm_addr_out] <= ddm_dat_in;
            dst_q <= UAM_DDM_NEXT;
          end
        end
        UAM_DDM_NEXT: begin
          dst_q <= UAM_DDM_IDLE;
          if (ditem_q == `UAM_DDM_ITEMS - 3'h1 || !pin_b_q[16 + dmod_q]) begin
            ditem_q <= '0;
            dmod_q <= (dmod_q == 4'hB) ? 4'h0 : dmod_q + 4'h1;
          end else ditem_q <= ditem_q + 3'h1;
        end
        default: dst_q <= UAM_DDM_IDLE;
      endcase
    end
  end
  a_ddm_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in || !ce_in)
    ddm_req_out && !ddm_ack_in |=> ddm_req_out && $stable(ddm_addr_out))
    else $error("diag request dropped");
  a_bvalid_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in || !ce_in)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  a_los_track: assert property (@(posedge clk_in) disable iff (!rst_n_in || !ce_in)
    ce_in[*3] |=> stm_los_out == $past(stm_los_in, 3)) else $error("los lag");
endmodule // uam_top
`default_nettype wire

// >>> tb/uam_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module uam_far_end (
  input wire logic clk_in, // Clock
  input wire logic rst_n_in, // Reset, active low
  input wire logic brk_in, // Spoil sync bytes on fibre one
  input wire logic dark_in, // No light on fibre one
  output logic [1:0][7:0] rx_dat_out, // Bytes to the card
  output logic [1:0] rx_vld_out, // Byte valid
  output logic [1:0] los_out // Optical loss pins
);
  logic [3:0] slot_q;
  logic [3:0] frm_q;
  logic [7:0] byte_d;
  assign byte_d = (slot_q == 4'h0) ? 8'hF6 : {slot_q, frm_q};
  assign los_out = {1'b0, dark_in};
  // A dark fibre toggles its data so stale bytes never look valid
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      slot_q <= 4'h0;
      frm_q <= 4'h0;
      rx_dat_out <= '0;
      rx_vld_out <= 2'b00;
    end else begin
      slot_q <= (slot_q == 4'hB) ? 4'h0 : slot_q + 4'h1;
      frm_q <= (slot_q == 4'hB) ? frm_q + 4'h1 : frm_q;
      rx_dat_out[1] <= byte_d;
      rx_dat_out[0] <= dark_in ? ~rx_dat_out[0] :
        ((brk_in && slot_q == 4'h0) ? 8'h55 : byte_d);
      rx_vld_out <= {1'b1, ~dark_in};
    end
  end
endmodule // uam_far_end
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "uam_defines.svh"
module tb;
  import uam_pkg::*;
  logic clk_in, rst_n_in, ce_in, ddm_ack_in, brk, dark, mon_en, ber_bad, rx_seen, ddm_req_out;
  logic irq_out;
  logic [10:0][7:0] ch_dat_in, rx_ch_dat_out;
  logic [10:0] ch_vld_in, ch_take_out, rx_ch_vld_out;
  logic [3:0] ge_eof_in, ge_los_in, ge_link_in, ge_an_en_out, ge_los_out, ge_link_out;
  logic [5:0] stm_fs_in, stm_rs_in, stm_los_in, stm_los_out, stm_err_out, ddm_addr_out;
  logic [5:0][7:0] stm_b1_in, stm_b2_in;
  logic [1:0][7:0] up_rx_dat_in;
  logic [1:0] up_rx_vld_in, up_los_in, up_tx_en_out, up_los_out, up_sync_out, rr;
  logic [11:0] ddm_fit_in;
  logic [15:0] ddm_dat_in;
  logic [7:0] up_tx_dat_out;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int err_count, check_count, cyc, pos;
  uam_top #(.BER_WIN(64)) DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .ch_dat_in(ch_dat_in), .ch_vld_in(ch_vld_in), .ge_eof_in(ge_eof_in), .stm_fs_in(stm_fs_in),
    .stm_rs_in(stm_rs_in), .stm_b1_in(stm_b1_in), .stm_b2_in(stm_b2_in),
    .up_rx_dat_in(up_rx_dat_in), .up_rx_vld_in(up_rx_vld_in), .up_los_in(up_los_in),
    .ge_los_in(ge_los_in), .ge_link_in(ge_link_in), .stm_los_in(stm_los_in),
    .ddm_fit_in(ddm_fit_in), .ddm_ack_in(ddm_ack_in), .ddm_dat_in(ddm_dat_in),
    .ch_take_out(ch_take_out), .up_tx_dat_out(up_tx_dat_out), .up_tx_en_out(up_tx_en_out),
    .rx_ch_dat_out(rx_ch_dat_out), .rx_ch_vld_out(rx_ch_vld_out), .ge_an_en_out(ge_an_en_out),
    .up_los_out(up_los_out), .up_sync_out(up_sync_out), .ge_los_out(ge_los_out),
    .ge_link_out(ge_link_out), .stm_los_out(stm_los_out), .stm_err_out(stm_err_out),
    .ddm_req_out(ddm_req_out), .ddm_addr_out(ddm_addr_out), .irq_out(irq_out),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  uam_far_end far (.clk_in(clk_in), .rst_n_in(rst_n_in), .brk_in(brk), .dark_in(dark),
    .rx_dat_out(up_rx_dat_in), .rx_vld_out(up_rx_vld_in), .los_out(up_los_in));
  // ----
  // Tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge clk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----
  // Clock, monitors, diagnostics responder, frame starts
  // ----
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial begin
    wait (cyc >= 20000);
    err_count++;
    end_sim();
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (mon_en && pos >= 1 && pos <= 11) chk("tx slot", up_tx_dat_out, ch_dat_in[pos-1]);
    if (mon_en && pos >= 1 && pos <= 11) chk("take", ch_take_out, 32'h1 << (pos - 1));
    pos <= (up_tx_dat_out == 8'hF6) ? 1 : pos + 1;
    for (int k = 0; k < 11; k++) begin
      if (rx_ch_vld_out[k]) chk("rx slot", rx_ch_dat_out[k][7:4], k + 1);
    end
    if (|rx_ch_vld_out) rx_seen <= 1'b1;
    if (ddm_req_out && !ddm_ack_in) chk("diag index", ddm_addr_out < 6'h05 ||
      (ddm_addr_out > 6'h36 && ddm_addr_out < 6'h3C), 1);
    ddm_ack_in <= ddm_req_out && !ddm_ack_in;
    ddm_dat_in <= {10'h000, ddm_addr_out};
    stm_fs_in <= (cyc % 96 == 0) ? 6'h3F : 6'h00;
    stm_b1_in <= ber_bad ? {6{8'hFF}} : '0;
    stm_b2_in <= ber_bad ? {6{8'hFF}} : '0;
  end
  initial begin
    {cyc, pos, err_count, check_count} = '0;
    {rst_n_in, brk, dark, mon_en, ber_bad, rx_seen, ddm_ack_in} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ddm_dat_in, stm_b1_in, stm_b2_in} = '0;
    {ge_eof_in, stm_rs_in, stm_fs_in, ge_los_in, ge_link_in, stm_los_in} = '0;
    ce_in = 1'b1;
    s_axi_wstrb = 4'hF;
    ddm_fit_in = 12'h801;
    ch_vld_in = 11'h7FF;
    for (int k = 0; k < 11; k++) ch_dat_in[k] = 8'h10 + 8'(k);
    w(16);
    rst_n_in <= 1'b1;
    rd(`UAM_OFS_CTRL);
    chk("ctrl reset", rv, `UAM_CTRL_RST);
    rd(`UAM_OFS_MASK);
    chk("mask reset", rv, `UAM_MASK_RST);
    rd(6'h18);
    chk("unmapped read", rv, 32'h0);
    chk("unmapped rresp", rr, 2'b10);
    wr(6'h1C, 32'hFFFFFFFF);
    chk("unmapped write", rr, 2'b10);
    mon_en <= 1'b1;
    w(400);
    mon_en <= 1'b0;
    chk("tx framing", pos < 13, 1);
    chk("rx seen", rx_seen, 1);
    chk("sync", up_sync_out, 2'b01);
    chk("laser", up_tx_en_out, 2'b01);
    chk("autoneg", ge_an_en_out, 4'hF);
    wr(`UAM_OFS_CTRL, 32'h14);
    w(3);
    chk("forced", ge_an_en_out, 4'h5);
    wr(`UAM_OFS_CTRL, 32'h0);
    wr(`UAM_OFS_MASK, 32'h1FFFFFFF);
    wr(`UAM_OFS_EVT, 32'h1FFFFFFF);
    w(4);
    chk("irq idle", irq_out, 0);
    ge_los_in <= 4'h9;
    ge_link_in <= 4'h6;
    stm_los_in <= 6'h2A;
    w(6);
    chk("ge los", ge_los_out, 4'h9);
    chk("ge link", ge_link_out, 4'h6);
    chk("stm los", stm_los_out, 6'h2A);
    chk("irq set", irq_out, 1);
    rd(`UAM_OFS_LIVE);
    chk("live", rv, 32'h0002A694);
    rd(`UAM_OFS_EVT);
    chk("events", rv, 32'h0002A690);
    wr(`UAM_OFS_MASK, 32'h0);
    w(3);
    chk("irq masked", irq_out, 0);
    wr(`UAM_OFS_MASK, 32'h1FFFFFFF);
    wr(`UAM_OFS_EVT, 32'h1FFFFFFF);
    w(3);
    chk("irq cleared", irq_out, 0);
    wr(`UAM_OFS_CTRL, 32'h1);
    w(200);
    chk("laser two", up_tx_en_out, 2'b11);
    chk("sync two", up_sync_out, 2'b11);
    brk <= 1'b1;
    w(100);
    chk("sync lost", up_sync_out[0], 0);
    rd(`UAM_OFS_LIVE);
    chk("switched", rv[24], 1);
    rd(`UAM_OFS_EVT);
    chk("switch event", rv[24], 1);
    brk <= 1'b0;
    wr(`UAM_OFS_CTRL, 32'h0);
    w(8);
    chk("laser off", up_tx_en_out, 2'b01);
    chk("two down", up_sync_out[1], 0);
    wr(`UAM_OFS_CTRL, 32'h1);
    w(60);
    dark <= 1'b1;
    w(10);
    chk("up los", up_los_out, 2'b01);
    rd(`UAM_OFS_LIVE);
    chk("los switch", rv[24], 1);
    dark <= 1'b0;
    w(10);
    chk("up los gone", up_los_out, 2'b00);
    wr(`UAM_OFS_CTRL, 32'h0);
    wr(`UAM_OFS_DIDX, 32'h39);
    w(600);
    rd(`UAM_OFS_DDAT);
    chk("diag value", rv, 32'h39);
    for (int k = 0; k < 6; k++) ch_dat_in[k] <= 8'h00;
    ber_bad <= 1'b1;
    w(4000);
    chk("err set", stm_err_out, 6'h3F);
    ber_bad <= 1'b0;
    w(4000);
    chk("err clear", stm_err_out, 6'h00);
    end_sim();
  end
endmodule // tb
`default_nettype wire
